/* File: rtl/iousc_regs.vh */
`ifndef IOUSC_REGS_VH
`define IOUSC_REGS_VH
// Timing figures as printed, in ns
`define IOUSC_CLK_NS 100
`define IOUSC_REQ_DROP_NS 250000
`define IOUSC_INH_DROP_NS 1500
`define IOUSC_DISC_DROP_NS 6000
`define IOUSC_FWD_NS 1800
`define IOUSC_INB_DROP_NS 1500
`define IOUSC_ADDR_SETUP_NS 250
`define IOUSC_ADDR_LEAD_NS 400
`define IOUSC_GATE_LOW_NS 4000
// Cycle budgets derived from the figures (integer division rounds every time down)
`define IOUSC_REQ_DROP_CYC (`IOUSC_REQ_DROP_NS / `IOUSC_CLK_NS)
`define IOUSC_INH_DROP_CYC (`IOUSC_INH_DROP_NS / `IOUSC_CLK_NS)
`define IOUSC_DISC_DROP_CYC (`IOUSC_DISC_DROP_NS / `IOUSC_CLK_NS)
`define IOUSC_FWD_CYC (`IOUSC_FWD_NS / `IOUSC_CLK_NS)
// Odd parity bit position on a bus word {p, b0..b7}
`define IOUSC_PAR_BIT 8
// Selection sequence states
`define IOUSC_ST_IDLE 3'h0
`define IOUSC_ST_PASS 3'h1
`define IOUSC_ST_ADDR 3'h2
`define IOUSC_ST_WAIT 3'h3
`define IOUSC_ST_DISC 3'h4
`define IOUSC_ST_DONE 3'h5
`endif

/* File: rtl/iousc_sync.v */
`timescale 1ns/1ns
module iousc_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire resetn,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule

/* File: rtl/iousc_unit.v */
`timescale 1ns/1ns
`include "iousc_regs.vh"
// Notes on behaviour
// - Request only when status or data ready
// - Drop request after satisfied disconnect, bounded
// - Suppressible request drops when inhibit rises
// - Decode address while strobe up, connect
// - Strobe with poll low forces disconnect
// - Motion finishes; status offered later
// - Unneeded poll passes to next unit
// - Poll latch set by poll and gate
// - Poll counts only while gate high
// - Connect only on incoming poll rise
// - Forward unwanted poll within 1.8 us
// - Connected until last byte acknowledged
// - Connect blocks poll to lower units
// - Return path behaves like outgoing poll
// - Inbound lines drop after disconnect
// - Connected unit sends address byte
// - Channel inactive resets everything
// - Bus bytes carry odd parity
module iousc_unit #(
  parameter [7:0] UNIT_ADDR = 8'h00
) (
  input wire clk,
  input wire resetn,
  input wire [8:0] bus_out,
  input wire addr_strobe,
  input wire poll_in,
  input wire poll_gate,
  input wire channel_active,
  input wire inhibit_line,
  input wire tag_ack_out,
  input wire dev_ready,
  input wire dev_suppressible,
  input wire dev_last_byte,
  output reg [8:0] bus_in,
  output reg addr_in,
  output reg service_request,
  output reg unit_connected,
  output reg poll_out,
  output reg busy_status_strobe,
  output reg parity_error,
  output reg dev_disconnected
);
  // ==========================================================
  // Input synchronisers
  wire [8:0] bo_s;
  wire as_s;
  wire pi_s;
  wire pg_s;
  wire ca_s;
  wire ih_s;
  wire ack_s;

  // Bus bits may land a cycle apart; strobe lead over the poll covers it
  iousc_sync #(.W(9)) u_sb (
    .clk(clk),
    .resetn(resetn),
    .d(bus_out),
    .q(bo_s)
  );

  iousc_sync #(.W(1)) u_as (
    .clk(clk),
    .resetn(resetn),
    .d(addr_strobe),
    .q(as_s)
  );

  iousc_sync #(.W(1)) u_pi (
    .clk(clk),
    .resetn(resetn),
    .d(poll_in),
    .q(pi_s)
  );

  iousc_sync #(.W(1)) u_pg (
    .clk(clk),
    .resetn(resetn),
    .d(poll_gate),
    .q(pg_s)
  );

  iousc_sync #(.W(1)) u_ca (
    .clk(clk),
    .resetn(resetn),
    .d(channel_active),
    .q(ca_s)
  );

  iousc_sync #(.W(1)) u_ih (
    .clk(clk),
    .resetn(resetn),
    .d(inhibit_line),
    .q(ih_s)
  );

  iousc_sync #(.W(1)) u_ack (
    .clk(clk),
    .resetn(resetn),
    .d(tag_ack_out),
    .q(ack_s)
  );

  // ==========================================================
  // Address match and parity, bit by bit
  wire [7:0] addr_eq;
  wire [8:0] par_chain;
  wire [7:0] own_chain;
  assign par_chain[0] = bo_s[0];
  assign own_chain[0] = UNIT_ADDR[0];
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
      assign addr_eq[gi] = (bo_s[gi] == UNIT_ADDR[gi]);
      assign par_chain[gi + 1] = par_chain[gi] ^ bo_s[gi + 1];
      if (gi > 0) begin : g_own
        assign own_chain[gi] = own_chain[gi - 1] ^ UNIT_ADDR[gi];
      end
    end
  endgenerate

  // ==========================================================
  // Poll latch and gating
  reg latch_q;
  reg pi_prev_q;
  reg armed_q;
  reg [2:0] st_q;
  reg [2:0] st_d;
  wire poll_act = pi_s & pg_s;
  wire poll_rise = latch_q & ~pi_prev_q;
  wire addr_hit = as_s & (&addr_eq);
  wire par_ok = par_chain[8];
  wire want = dev_ready & ~(dev_suppressible & ih_s);
  wire bi_par = ~own_chain[7];

  // Latch rides through poll glitches while the gate stays up
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_q <= 1'b0;
    end else if (!ca_s || !pg_s) begin
      latch_q <= 1'b0;
    end else if (poll_act) begin
      latch_q <= 1'b1;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pi_prev_q <= 1'b0;
    end else if (!ca_s || !pg_s) begin
      pi_prev_q <= 1'b0;
    end else begin
      pi_prev_q <= latch_q;
    end
  end

  // ==========================================================
  // Selection sequence
  always @* begin
    st_d = st_q;
    case (st_q)
      `IOUSC_ST_IDLE: begin
        if (poll_rise && armed_q && (addr_hit || (want && !as_s))) begin
          st_d = `IOUSC_ST_ADDR;
        end else if (poll_rise) begin
          st_d = `IOUSC_ST_PASS;
        end
      end
      `IOUSC_ST_PASS: begin
        if (!latch_q) begin
          st_d = `IOUSC_ST_IDLE;
        end
      end
      `IOUSC_ST_ADDR: begin
        // The latch holds while the gate is up, so the raw gated poll decides here
        if (as_s && !poll_act) begin
          st_d = `IOUSC_ST_DISC;
        end else if (ack_s) begin
          st_d = `IOUSC_ST_WAIT;
        end
      end
      `IOUSC_ST_WAIT: begin
        if (as_s && !poll_act) begin
          st_d = `IOUSC_ST_DISC;
        end else if (!poll_act && ack_s && dev_last_byte) begin
          st_d = `IOUSC_ST_DONE;
        end
      end
      `IOUSC_ST_DISC: begin
        st_d = `IOUSC_ST_DONE;
      end
      `IOUSC_ST_DONE: begin
        if (!latch_q) begin
          st_d = `IOUSC_ST_IDLE;
        end
      end
      default: begin
        st_d = `IOUSC_ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= `IOUSC_ST_IDLE;
    end else if (!ca_s) begin
      st_q <= `IOUSC_ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Re-arm only once the poll latch has cleared, which needs the gate (or channel active) low
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      armed_q <= 1'b0;
    end else if (!ca_s) begin
      armed_q <= 1'b0;
    end else if (st_d == `IOUSC_ST_PASS) begin
      armed_q <= 1'b0;
    end else if (!latch_q) begin
      armed_q <= 1'b1;
    end
  end

  // ==========================================================
  // Outputs, all registered
  wire conn = (st_d == `IOUSC_ST_ADDR) || (st_d == `IOUSC_ST_WAIT);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      unit_connected <= 1'b0;
    end else if (!ca_s) begin
      unit_connected <= 1'b0;
    end else begin
      unit_connected <= conn;
    end
  end

  // Poll goes on only when not connecting; this also forms the return path
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      poll_out <= 1'b0;
    end else if (!ca_s) begin
      poll_out <= 1'b0;
    end else begin
      poll_out <= latch_q & (st_d == `IOUSC_ST_PASS);
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_in <= 1'b0;
    end else if (!ca_s) begin
      addr_in <= 1'b0;
    end else begin
      addr_in <= (st_d == `IOUSC_ST_ADDR);
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_in <= 9'h000;
    end else if (!ca_s) begin
      bus_in <= 9'h000;
    end else begin
      bus_in <= (st_d == `IOUSC_ST_ADDR) ? {bi_par, UNIT_ADDR} : 9'h000;
    end
  end

  // Request held only while ready, not suppressed and not yet satisfied
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      service_request <= 1'b0;
    end else if (!ca_s) begin
      service_request <= 1'b0;
    end else begin
      service_request <= want && (st_d != `IOUSC_ST_DONE);
    end
  end

  // Busy sequence is not offered; the line stays low
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_status_strobe <= 1'b0;
    end else begin
      busy_status_strobe <= 1'b0;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      parity_error <= 1'b0;
    end else if (!ca_s) begin
      parity_error <= 1'b0;
    end else if (addr_hit && poll_rise) begin
      parity_error <= ~par_ok;
    end
  end

  // Device side finishes motion and reports status later
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dev_disconnected <= 1'b0;
    end else if (!ca_s) begin
      dev_disconnected <= 1'b0;
    end else begin
      dev_disconnected <= (st_d == `IOUSC_ST_DISC);
    end
  end
endmodule

/* File: test/io_unit_selection_chain_bench.sv */
`timescale 1ns/1ns
// ====================
// Bench top
module io_unit_selection_chain_bench;
  localparam [7:0] ADDR = 8'h5A;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg channel_active = 1'b0;
  reg inhibit_line = 1'b0;
  reg tag_ack_out = 1'b0;
  reg dev_ready = 1'b0;
  reg dev_supp = 1'b0;
  reg dev_last = 1'b0;
  integer fail_count = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  reg disc_seen = 1'b0;
  wire busy_strobe, parity_error, dev_disconnected;
  wire [8:0] bus_out, bus_in;
  wire addr_strobe, poll_in, poll_gate, addr_in, service_request, unit_connected, poll_out;
  always #50 clk = ~clk;
  iousc_chan chan (.clk(clk), .unit_connected(unit_connected), .poll_ret(poll_out),
    .bus_out(bus_out), .addr_strobe(addr_strobe), .poll_in(poll_in), .poll_gate(poll_gate));
  iousc_unit #(.UNIT_ADDR(ADDR)) DUT (.clk(clk), .resetn(resetn), .bus_out(bus_out),
    .addr_strobe(addr_strobe), .poll_in(poll_in), .poll_gate(poll_gate),
    .channel_active(channel_active), .inhibit_line(inhibit_line), .tag_ack_out(tag_ack_out),
    .dev_ready(dev_ready), .dev_suppressible(dev_supp), .dev_last_byte(dev_last),
    .bus_in(bus_in), .addr_in(addr_in), .service_request(service_request),
    .unit_connected(unit_connected), .poll_out(poll_out), .busy_status_strobe(busy_strobe),
    .parity_error(parity_error), .dev_disconnected(dev_disconnected));
  always @(posedge clk) if (dev_disconnected) disc_seen <= 1'b1;
  task chk(input [8:0] got, input [8:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task tally_and_finish;
    begin
      $display("checked %0d failed %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task t_select;
    begin
      chan.select(ADDR);
      tick(2);
      chk({unit_connected, poll_out, addr_in}, 9'h005);
      chk(bus_in, {~^ADDR, ADDR});
      chk({busy_strobe, parity_error}, 9'h000);
      chan.stop;
      chk(unit_connected, 9'h001);
      tag_ack_out <= 1'b1;
      dev_last <= 1'b1;
      tick(15);
      chk({unit_connected, bus_in}, 9'h000);
    end
  endtask
  task t_pass;
    begin
      tag_ack_out <= 1'b0;
      dev_last <= 1'b0;
      chan.select(8'hA5);
      chk({unit_connected, poll_out}, 9'h001);
      chan.stop;
      chk(poll_out, 9'h000);
    end
  endtask
  task t_disc;
    begin
      chan.select(ADDR);
      tick(2);
      chan.disconnect;
      chk({unit_connected, addr_in}, 9'h000);
      chk(disc_seen, 9'h001);
    end
  endtask
  task t_request;
    begin
      dev_ready <= 1'b1;
      tick(4);
      chk(service_request, 9'h001);
      chan.scan;
      tick(2);
      chk(unit_connected, 9'h001);
      dev_ready <= 1'b0;
      chan.stop;
      tag_ack_out <= 1'b1;
      dev_last <= 1'b1;
      tick(2500);
      chk(service_request, 9'h000);
      {tag_ack_out, dev_last, dev_ready, dev_supp} <= 4'hB;
      tick(4);
      inhibit_line <= 1'b1;
      tick(15);
      chk(service_request, 9'h000);
      {dev_ready, dev_supp, inhibit_line} <= 3'h0;
    end
  endtask
  task t_inactive;
    begin
      chan.select(ADDR);
      chan.stop;
      channel_active <= 1'b0;
      tick(15);
      chk({unit_connected, poll_out, addr_in, bus_in}, 9'h000);
    end
  endtask
  initial begin
    tick(8);
    resetn <= 1'b1;
    channel_active <= 1'b1;
    tick(4);
    t_select;
    t_pass;
    t_disc;
    t_request;
    t_inactive;
    tally_and_finish;
  end
  // Ceiling well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      tally_and_finish;
    end
  end
endmodule

/* File: test/iousc_assertions.sv */
`timescale 1ns/1ns
// ====================
// Unit pin checks
module iousc_assertions (
  input wire clk,
  input wire resetn,
  input wire addr_strobe,
  input wire poll_in,
  input wire channel_active,
  input wire inhibit_line,
  input wire dev_suppressible,
  input wire [8:0] bus_in,
  input wire addr_in,
  input wire service_request,
  input wire unit_connected,
  input wire poll_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  conn_block_a: assert property (unit_connected |-> !poll_out) else $error("pass");
  addr_conn_a: assert property (addr_in |-> unit_connected) else $error("addr");
  odd_parity_a: assert property (addr_in |-> ^bus_in) else $error("parity");
  conn_rise_a: assert property ($rose(unit_connected) |-> poll_in) else $error("rise");
  inact_clear_a: assert property ($fell(channel_active) |-> ##[1:15]
    !(unit_connected | poll_out | addr_in | service_request)) else $error("inact");
  disc_drop_a: assert property (addr_strobe && !poll_in && unit_connected
    |-> ##[1:60] !unit_connected) else $error("disc");
  inb_drop_a: assert property ($fell(unit_connected) |-> ##[0:15] !bus_in)
    else $error("inb");
  inh_drop_a: assert property ($rose(inhibit_line) && dev_suppressible
    |-> ##[1:15] !service_request) else $error("inh");
  cover property ($rose(unit_connected));
  cover property ($rose(poll_out));
  cover property ($fell(unit_connected) && addr_strobe);
endmodule
bind iousc_unit iousc_assertions chk (.*);

/* File: test/iousc_chan.sv */
`timescale 1ns/1ns
// ====================
// Channel model
module iousc_chan (
  input wire clk,
  input wire unit_connected,
  input wire poll_ret,
  output reg [8:0] bus_out,
  output reg addr_strobe,
  output reg poll_in,
  output reg poll_gate
);
  integer i;
  initial {bus_out, addr_strobe, poll_in, poll_gate} = 12'h000;
  task scan;
    begin
      poll_gate <= 1'b1;
      poll_in <= 1'b1;
      for (i = 0; i < 18 && !(unit_connected | poll_ret); i = i + 1) @(posedge clk);
    end
  endtask
  // Caller only selects with the chain quiet
  task select(input [7:0] a);
    begin
      bus_out <= {~^a, a};
      repeat (3) @(posedge clk);
      addr_strobe <= 1'b1;
      repeat (5) @(posedge clk);
      scan;
      addr_strobe <= 1'b0;
      bus_out <= ~bus_out;
    end
  endtask
  task stop;
    begin
      poll_in <= 1'b0;
      poll_gate <= 1'b0;
      repeat (40) @(posedge clk);
    end
  endtask
  task disconnect;
    begin
      poll_in <= 1'b0;
      addr_strobe <= 1'b1;
      for (i = 0; i < 60 && unit_connected; i = i + 1) @(posedge clk);
      addr_strobe <= 1'b0;
      stop;
    end
  endtask
endmodule
